// file: dv/cmbp_core_properties.sv
// Pin timing and bus handshake assertions for the pin control block
`timescale 1ns/100ps
module cmbp_core_properties #(
   parameter int unsigned MCLK_HALF = cmbp_pkg::MCLK_HALF_CYC
) (
   // Clock, reset and register bus
   input wire logic                      ref_clk,
   input wire logic                      resetn,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_ack_o,
   // Pins
   input wire cmbp_pkg::cmbp_pin_in_t    pin_i,
   input wire logic                      mclk_o,
   input wire cmbp_pkg::cmbp_addr_pins_t addr_pins_o,
   input wire logic                      addr_oe_n_o,
   input wire logic                      bidir_oe_n_o,
   input wire logic [31:0]               write_bus_o
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic       prev_q;
   logic       seen_q;
   logic [7:0] held_q;
   ////////////////////////////////////////////////////////////////////////
   // Phase length counter; the first toggle after reset is not judged
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
         held_q <= 8'h00;
      end else begin
         prev_q <= mclk_o;
         seen_q <= seen_q | (mclk_o != prev_q);
         held_q <= (mclk_o != prev_q) ? 8'h00 : held_q + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Four samples cover two sync flops plus the output stage
   a_addr_float_off: assert property (
      !pin_i.addr_tristate_enable [*4] |-> addr_oe_n_o)
      else $error("address pins driven while enable low");
   // Reset clears the syncs, so one more sample after release
   a_addr_drive_on: assert property (
      pin_i.addr_tristate_enable [*5] |-> !addr_oe_n_o)
      else $error("address pins floating while enable high");
   a_latch_freeze: assert property (
      !pin_i.addr_latch_enable [*5] |=> $stable(addr_pins_o))
      else $error("address pins moved while latched");
   a_split_low_zero: assert property (
      !pin_i.bus_split_select [*4] |-> write_bus_o == 32'h0000_0000)
      else $error("write bus not zero in bidirectional mode");
   a_drive_off_float: assert property (
      !pin_i.data_drive_enable [*4]
      |-> bidir_oe_n_o && write_bus_o == 32'h0000_0000)
      else $error("data output while drive enable low");
   a_mclk_phase_len: assert property (
      seen_q && (mclk_o != prev_q) |-> held_q == 8'(MCLK_HALF - 1))
      else $error("main clock phase length wrong");
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no acknowledge one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   // Main scenarios reached
   c_cycle_start: cover property (!addr_oe_n_o && $rose(mclk_o));
   c_read_float: cover property ($rose(bidir_oe_n_o));
   c_split_write: cover property (write_bus_o != 32'h0000_0000);
endmodule // cmbp_core_properties

bind cmbp_core cmbp_core_properties #(.MCLK_HALF(MCLK_HALF))
   cmbp_core_properties_i (.ref_clk(ref_clk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .pin_i(pin_i), .mclk_o(mclk_o), .addr_pins_o(addr_pins_o),
   .addr_oe_n_o(addr_oe_n_o), .bidir_oe_n_o(bidir_oe_n_o),
   .write_bus_o(write_bus_o));

// file: dv/cmbp_core_tb.sv
// Self-checking bench for the memory bus pin control block
`timescale 1ns/100ps
module cmbp_core_tb;
   logic                      ref_clk, resetn, cyc, stb, we, ack;
   logic                      mclk, aoe_n, boe_n, abort;
   logic [7:0]                adr;
   logic [31:0]               dat_w, dat_r, bidir_o, wbus, blevel, rbus;
   logic [31:0]               q, rd;
   cmbp_pkg::cmbp_addr_pins_t apins;
   cmbp_pkg::cmbp_pin_in_t    cfg_q, pins;
   int                        miscompares, samples_checked;
   ////////////////////////////////////////////////////////////////////////
   // Design, memory model and pin merge
   cmbp_core #(.MCLK_HALF(cmbp_pkg::MCLK_HALF_CYC)) cmbp_core_i (
      .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .pin_i(pins), .mclk_o(mclk), .addr_pins_o(apins),
      .addr_oe_n_o(aoe_n), .bidir_data_o(bidir_o), .bidir_oe_n_o(boe_n),
      .write_bus_o(wbus));
   cmbp_mem_model cmbp_mem_model_i (.ref_clk(ref_clk), .mclk(mclk),
      .addr_pins(apins), .addr_oe_n(aoe_n), .bidir_out(bidir_o),
      .bidir_oe_n(boe_n), .write_bus(wbus), .split(cfg_q.bus_split_select),
      .bidir_level(blevel), .read_bus(rbus), .abort(abort));
   always_comb begin
      pins = cfg_q;
      pins.bidir_data_in = blevel;
      pins.read_bus = rbus;
      pins.mem_abort = abort;
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold until ack is sampled high, then release
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge ref_clk); while (ack !== 1'b1);
      r = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic access(input logic [31:0] a, input logic [5:0] attr,
                         input logic [31:0] wd, output logic [31:0] r);
      wb(1'b1, cmbp_pkg::OFF_ADDR, a, r);
      wb(1'b1, cmbp_pkg::OFF_ATTR, {26'h0, attr}, r);
      wb(1'b1, cmbp_pkg::OFF_WDATA, wd, r);
      wb(1'b1, cmbp_pkg::OFF_CTRL, 32'h1, r);
      do wb(1'b0, cmbp_pkg::OFF_STATUS, 32'h0, r); while (r[0] === 1'b1);
      wb(1'b0, cmbp_pkg::OFF_RDATA, 32'h0, r);
   endtask
   task automatic settle;
      repeat (5) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_word;
      logic [5:0] at;
      wb(1'b0, 8'hFC, 32'h0, q);
      check(q, 32'h0);
      access(32'h4, 6'h06, 32'hA5C3_0F12, q);
      access(32'h4, 6'h3A, 32'h0, rd);
      check(rd, 32'hA5C3_0F12);
      check(apins.addr, 32'h4);
      at = {apins.lock, apins.privilege_flag, apins.instr_fetch_flag,
            apins.write_not_read, apins.access_size};
      check({26'h0, at}, 32'h0000_003A);
   endtask
   task automatic t_endian;
      logic [31:0] w;
      w = 32'h4433_2211;
      cmbp_mem_model_i.mem[2] = w;
      for (int b = 0; b < 2; b++) begin
         cfg_q.endian_select <= b[0];
         settle();
         for (int k = 0; k < 4; k++) begin
            access(32'h8 + k, 6'h00, 32'h0, rd);
            check(rd, {24'h0, w[8 * (b ? 3 - k : k) +: 8]});
         end
         for (int k = 0; k < 2; k++) begin
            access(32'h8 + 2 * k, 6'h01, 32'h0, rd);
            check(rd, {16'h0, w[16 * (b ? 1 - k : k) +: 16]});
         end
      end
      cfg_q.endian_select <= 1'b0;
   endtask
   task automatic t_split;
      cfg_q.bus_split_select <= 1'b1;
      settle();
      access(32'hC, 6'h06, 32'h3C5A_9617, q);
      access(32'hC, 6'h02, 32'h0, rd);
      check(rd, 32'h3C5A_9617);
      cmbp_mem_model_i.mem[4] = 32'h8877_6655;
      cfg_q.byte_lane_capture <= 4'h1;
      settle();
      access(32'h10, 6'h02, 32'h0, rd);
      check(rd, 32'h3C5A_9655);
      cfg_q.byte_lane_capture <= 4'hF;
      cfg_q.addr_pipe_select <= 1'b1;
      settle();
      access(32'h10, 6'h02, 32'h0, rd);
      check(rd, 32'h8877_6655);
      check(apins.addr, 32'h0);
      cfg_q.addr_pipe_select <= 1'b0;
      cfg_q.bus_split_select <= 1'b0;
      settle();
   endtask
   task automatic t_abort_float;
      access(32'h8000_0000, 6'h02, 32'h0, rd);
      wb(1'b0, cmbp_pkg::OFF_STATUS, 32'h0, q);
      check(q[1], 1'b1);
      wb(1'b1, cmbp_pkg::OFF_STATUS, 32'h2, q);
      wb(1'b0, cmbp_pkg::OFF_STATUS, 32'h0, q);
      check(q[1], 1'b0);
      cfg_q.addr_latch_enable <= 1'b0;
      settle();
      access(32'h4, 6'h02, 32'h0, rd);
      check(apins.addr, 32'h8000_0000);
      cfg_q.addr_latch_enable <= 1'b1;
      cfg_q.addr_tristate_enable <= 1'b0;
      cfg_q.data_drive_enable <= 1'b0;
      settle();
      check(aoe_n, 1'b1);
      check(boe_n, 1'b1);
      cfg_q.addr_tristate_enable <= 1'b1;
      cfg_q.data_drive_enable <= 1'b1;
      settle();
      check(aoe_n, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Verdict, watchdog and main sequence
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked,
               miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      end_of_test();
   end
   initial begin
      {cyc, stb, we, adr, dat_w} = '0;
      cfg_q = '0;
      cfg_q.addr_tristate_enable = 1'b1;
      cfg_q.addr_latch_enable = 1'b1;
      cfg_q.byte_lane_capture = 4'hF;
      cfg_q.data_drive_enable = 1'b1;
      miscompares = 0;
      samples_checked = 0;
      resetn = 1'b0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_word();
      t_endian();
      t_split();
      t_abort_float();
      end_of_test();
   end
endmodule // cmbp_core_tb

// file: dv/cmbp_mem_model.sv
// Memory system model on the far side of the pin control block
`timescale 1ns/100ps
module cmbp_mem_model (
   // Clock and pins from the block
   input  wire logic                      ref_clk,
   input  wire logic                      mclk,
   input  wire cmbp_pkg::cmbp_addr_pins_t addr_pins,
   input  wire logic                      addr_oe_n,
   input  wire logic [31:0]               bidir_out,
   input  wire logic                      bidir_oe_n,
   input  wire logic [31:0]               write_bus,
   input  wire logic                      split,
   // Pins to the block
   output logic      [31:0]               bidir_level,
   output logic      [31:0]               read_bus,
   output logic                           abort
);
   logic [31:0]               mem [16];
   cmbp_pkg::cmbp_addr_pins_t cur_q;
   logic                      mclk_q;
   logic                      fresh_q;
   logic [31:0]               rd_w;
   ////////////////////////////////////////////////////////////////////////
   // Decode in the high phase: pipelined pins are gone after the fall
   // One write per new address phase: pins held while idle are no cycle
   always @(posedge ref_clk) begin
      mclk_q <= mclk;
      if (mclk && !addr_oe_n) begin
         cur_q <= addr_pins;
         if (addr_pins !== cur_q)
            fresh_q <= 1'b1;
      end
      if (mclk_q && !mclk) begin
         fresh_q <= 1'b0;
         if (fresh_q === 1'b1 && cur_q.write_not_read === 1'b1)
            mem[cur_q.addr[5:2]] <= split ? write_bus : bidir_out;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Unused read bus tied low; an open bidir bus shows junk when split, read data otherwise
   assign rd_w = mem[cur_q.addr[5:2]];
   assign read_bus = split ? rd_w : 32'h0000_0000;
   assign bidir_level = !bidir_oe_n ? bidir_out : (split ? ~rd_w : rd_w);
   assign abort = cur_q.addr[31];
endmodule // cmbp_mem_model

// file: logic/cmbp_core.sv
// Memory bus pin control: register access, sequencing and pin drive
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module cmbp_core #(
   parameter int unsigned MCLK_HALF = cmbp_pkg::MCLK_HALF_CYC
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      resetn,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   // Memory side pins in
   input  wire cmbp_pkg::cmbp_pin_in_t    pin_i,
   // Main clock and address pins out
   output logic                           mclk_o,
   output cmbp_pkg::cmbp_addr_pins_t      addr_pins_o,
   output logic                           addr_oe_n_o,
   // Data pins out
   output logic      [31:0]               bidir_data_o,
   output logic                           bidir_oe_n_o,
   output logic      [31:0]               write_bus_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check: eight-bit divider; the two input syncs eat two
   // cycles of each half period, so read data needs at least three
   if (MCLK_HALF < 3 || MCLK_HALF > 255) begin : g_bad_half
      $error("MCLK_HALF must lie between 3 and 255");
   end

   // Write merge under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // First byte lane of an access for size, address and endianness
   function automatic logic [1:0] lane_of(input logic [1:0] a,
                                          input logic [1:0] size,
                                          input logic       big);
      logic [1:0] r;
      r = 2'h0;
      if (size == cmbp_pkg::SIZE_BYTE) begin
         r = big ? ~a : a;
      end else if (size == cmbp_pkg::SIZE_HALF) begin
         r = {(big ? ~a[1] : a[1]), 1'b0};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   cmbp_pkg::cmbp_pin_in_t    sync1_q;
   cmbp_pkg::cmbp_pin_in_t    pin_s;
   cmbp_pkg::cmbp_state_t     state_q;
   cmbp_pkg::cmbp_state_t     state_d;
   cmbp_pkg::cmbp_addr_pins_t pins_q;
   cmbp_pkg::cmbp_addr_pins_t pins_d;
   cmbp_pkg::cmbp_addr_pins_t req_pins_w;
   logic [7:0]  div_q;
   logic        mclk_q;
   logic        tick_w;
   logic        rise_w;
   logic        fall_w;
   logic [31:0] addr_q;
   logic [5:0]  attr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic [31:0] lat_q;
   logic [31:0] lat_d;
   logic        abort_q;
   logic        pipe_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        oe_n_q;
   logic        d_oe_n_q;
   logic [31:0] d_out_q;
   logic [31:0] wbus_q;
   logic        req_w;
   logic        wr_w;
   logic        hit_addr;
   logic        hit_attr;
   logic        hit_wdata;
   logic        hit_ctrl;
   logic        hit_status;
   logic        hit_rdata;
   logic        busy_w;
   logic        start_w;
   logic        abort_clr_w;
   logic        load_w;
   logic        release_w;
   logic        rd_cyc_w;
   logic        drive_w;
   logic [1:0]  lane_w;
   logic [4:0]  shift_w;
   logic [31:0] placed_w;
   logic [31:0] picked_w;
   logic [31:0] extract_w;
   logic [31:0] src_w;
   logic [31:0] status_w;
   logic [31:0] rd_mux_w;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers on every pin input
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= '0;
         pin_s   <= '0;
      end else begin
         sync1_q <= pin_i;
         pin_s   <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main clock divider; edges are one-cycle enables, not a second clock
   assign tick_w = (div_q == 8'(MCLK_HALF - 1));
   assign rise_w = tick_w & ~mclk_q;
   assign fall_w = tick_w & mclk_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_q  <= 8'h00;
         mclk_q <= 1'b0;
      end else begin
         div_q  <= tick_w ? 8'h00 : div_q + 8'h01;
         mclk_q <= mclk_q ^ tick_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone decode; a request is served once, ack one cycle later
   assign req_w      = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_w       = req_w & wb_we_i;
   assign hit_addr   = (wb_adr_i == cmbp_pkg::OFF_ADDR);
   assign hit_attr   = (wb_adr_i == cmbp_pkg::OFF_ATTR);
   assign hit_wdata  = (wb_adr_i == cmbp_pkg::OFF_WDATA);
   assign hit_ctrl   = (wb_adr_i == cmbp_pkg::OFF_CTRL);
   assign hit_status = (wb_adr_i == cmbp_pkg::OFF_STATUS);
   assign hit_rdata  = (wb_adr_i == cmbp_pkg::OFF_RDATA);
   assign busy_w     = (state_q != cmbp_pkg::ST_IDLE);
   assign start_w    = wr_w & hit_ctrl & wb_sel_i[0] & ~busy_w
                     & wb_dat_i[cmbp_pkg::CTRL_START_BIT];
   assign abort_clr_w = wr_w & hit_status & wb_sel_i[0]
                      & wb_dat_i[cmbp_pkg::ST_ABORT_BIT];

   // Status word: live sequencer state and synchronised straps
   assign status_w = {27'h0,
                      pipe_q,
                      pin_s.bus_split_select,
                      pin_s.endian_select,
                      abort_q,
                      busy_w};

   // Read mux; unmapped offsets answer with zero
   assign rd_mux_w = hit_addr   ? addr_q :
                     hit_attr   ? {26'h0, attr_q} :
                     hit_wdata  ? wdata_q :
                     hit_status ? status_w :
                     hit_rdata  ? rdata_q : 32'h0000_0000;

   // Ack and read data; request fields are frozen while busy
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         dat_q <= cmbp_pkg::RST_WORD;
      end else begin
         ack_q <= req_w;
         dat_q <= req_w ? rd_mux_w : dat_q;
      end
   end

   // Request registers, written only while no access is running
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         addr_q  <= cmbp_pkg::RST_WORD;
         attr_q  <= cmbp_pkg::RST_ATTR;
         wdata_q <= cmbp_pkg::RST_WORD;
      end else if (wr_w && !busy_w) begin
         if (hit_addr) begin
            addr_q <= merge(addr_q, wb_dat_i, wb_sel_i);
         end
         if (hit_attr && wb_sel_i[0]) begin
            attr_q <= wb_dat_i[5:0];
         end
         if (hit_wdata) begin
            wdata_q <= merge(wdata_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer: a memory cycle runs from one main clock rise
   // to the next, with capture at the fall between them
   always_comb begin
      state_d = state_q;
      case (state_q)
         cmbp_pkg::ST_IDLE: begin
            if (start_w) begin
               state_d = pin_s.addr_pipe_select ? cmbp_pkg::ST_EARLY
                                                : cmbp_pkg::ST_ALIGN;
            end
         end
         cmbp_pkg::ST_EARLY: begin
            if (rise_w) begin
               state_d = cmbp_pkg::ST_CYCLE;
            end
         end
         cmbp_pkg::ST_ALIGN: begin
            if (rise_w) begin
               state_d = cmbp_pkg::ST_CYCLE;
            end
         end
         cmbp_pkg::ST_CYCLE: begin
            if (rise_w) begin
               state_d = cmbp_pkg::ST_IDLE;
            end
         end
         default: state_d = cmbp_pkg::ST_IDLE;
      endcase
   end

   // Mode is caught at start so a strap change cannot split an access
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= cmbp_pkg::ST_IDLE;
         pipe_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pipe_q  <= start_w ? pin_s.addr_pipe_select : pipe_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address and attribute pins
   assign req_pins_w = '{addr:             addr_q,
                         lock:             attr_q[cmbp_pkg::ATTR_LOCK_BIT],
                         access_size:      attr_q[cmbp_pkg::ATTR_SIZE_LSB +: 2],
                         write_not_read:   attr_q[cmbp_pkg::ATTR_WNR_BIT],
                         instr_fetch_flag: attr_q[cmbp_pkg::ATTR_FETCH_BIT],
                         privilege_flag:   attr_q[cmbp_pkg::ATTR_PRIV_BIT]};

   // Pipelined loads at start, ahead of the cycle; depipelined at its rise
   assign load_w = (start_w & pin_s.addr_pipe_select)
                 | ((state_q == cmbp_pkg::ST_ALIGN) & rise_w);
   // Pipelined drops the address once data is taken mid-cycle
   assign release_w = (state_q == cmbp_pkg::ST_CYCLE) & fall_w & pipe_q;

   // A low latch input freezes the pins at their present values
   always_comb begin
      pins_d = pins_q;
      if (pin_s.addr_latch_enable) begin
         if (load_w) begin
            pins_d = req_pins_w;
         end else if (release_w) begin
            pins_d = '0;
         end
      end
   end

   // Address enable low floats address and attributes together
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pins_q <= '0;
         oe_n_q <= 1'b1;
      end else begin
         pins_q <= pins_d;
         oe_n_q <= ~pin_s.addr_tristate_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data lane placement for writes
   assign lane_w   = lane_of(addr_q[1:0],
                             attr_q[cmbp_pkg::ATTR_SIZE_LSB +: 2],
                             pin_s.endian_select);
   assign shift_w  = {lane_w, 3'b000};
   assign placed_w = wdata_q << shift_w;
   assign rd_cyc_w = (state_q == cmbp_pkg::ST_CYCLE)
                   & ~attr_q[cmbp_pkg::ATTR_WNR_BIT];
   // Driven in all but read cycles, and only with drive enable high
   assign drive_w  = pin_s.data_drive_enable & ~rd_cyc_w;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         d_oe_n_q <= 1'b1;
         d_out_q  <= cmbp_pkg::RST_WORD;
         wbus_q   <= cmbp_pkg::RST_WORD;
      end else begin
         d_oe_n_q <= ~drive_w;
         d_out_q  <= placed_w;
         // Write bus carries data only when split and enabled
         wbus_q   <= (pin_s.bus_split_select && pin_s.data_drive_enable)
                   ? placed_w : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read capture; the unused bus is never looked at
   assign src_w = pin_s.bus_split_select ? pin_s.read_bus
                                         : pin_s.bidir_data_in;

   // Each lane latches at the fall only while its capture input is high
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign lat_d[g*8 +: 8] = (fall_w && pin_s.byte_lane_capture[g])
                             ? src_w[g*8 +: 8] : lat_q[g*8 +: 8];
   end

   // Sub-word reads come back right-aligned and zero-extended
   assign picked_w  = lat_q >> shift_w;
   assign extract_w =
      (attr_q[cmbp_pkg::ATTR_SIZE_LSB +: 2] == cmbp_pkg::SIZE_BYTE)
         ? {24'h0, picked_w[7:0]} :
      (attr_q[cmbp_pkg::ATTR_SIZE_LSB +: 2] == cmbp_pkg::SIZE_HALF)
         ? {16'h0, picked_w[15:0]} : picked_w;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lat_q   <= cmbp_pkg::RST_WORD;
         rdata_q <= cmbp_pkg::RST_WORD;
      end else begin
         lat_q   <= lat_d;
         if (rd_cyc_w && rise_w) begin
            rdata_q <= extract_w;
         end
      end
   end

   // Abort is sampled at the capture edge; a new abort beats the clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         abort_q <= 1'b0;
      end else if ((state_q == cmbp_pkg::ST_CYCLE) && fall_w
                   && pin_s.mem_abort) begin
         abort_q <= 1'b1;
      end else if (abort_clr_w) begin
         abort_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops
   assign wb_dat_o     = dat_q;
   assign wb_ack_o     = ack_q;
   assign mclk_o       = mclk_q;
   assign addr_pins_o  = pins_q;
   assign addr_oe_n_o  = oe_n_q;
   assign bidir_data_o = d_out_q;
   assign bidir_oe_n_o = d_oe_n_q;
   assign write_bus_o  = wbus_q;

endmodule // cmbp_core

// file: logic/cmbp_pkg.sv
// Constants, types and layouts for the memory bus pin control block
// Operation
// - Drive 32-bit address under latch/enable/pipe control
// - Tristate low floats address and attribute outputs
// - Latch input low holds address and attributes
// - Pipe select chooses pipelined or depipelined timing
// - Pipelined: address early, released before cycle end
// - Depipelined: address and attributes stable whole cycle
// - Endian select high big, low little
// - Falling clock captures lanes with capture high
// - Split low: bidir bus, write bus zero
// - Split high: unidirectional buses, bidir ignored
// - Bidir bus driven except during read cycles
// - Drive enable low floats bidir, suppresses writes
package cmbp_pkg;
   localparam int unsigned DW = 32;
   // Register byte offsets
   localparam logic [7:0] OFF_ADDR   = 8'h00;
   localparam logic [7:0] OFF_ATTR   = 8'h04;
   localparam logic [7:0] OFF_WDATA  = 8'h08;
   localparam logic [7:0] OFF_CTRL   = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RDATA  = 8'h14;
   // Field positions
   localparam int unsigned ATTR_SIZE_LSB  = 0;
   localparam int unsigned ATTR_WNR_BIT   = 2;
   localparam int unsigned ATTR_FETCH_BIT = 3;
   localparam int unsigned ATTR_PRIV_BIT  = 4;
   localparam int unsigned ATTR_LOCK_BIT  = 5;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_ABORT_BIT   = 1;
   localparam int unsigned ST_ENDIAN_SELECT_BIT  = 2;
   localparam int unsigned ST_SPLIT_BIT   = 3;
   localparam int unsigned ST_PIPE_BIT    = 4;
   // Access size codes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // Values after reset
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [5:0]  RST_ATTR = 6'h00;
   // Main clock half period; input syncs eat two ref cycles of it
   localparam int unsigned REF_CLK_NS    = 10;
   localparam int unsigned MCLK_HALF_NS  = 40;
   localparam int unsigned MCLK_HALF_CYC = MCLK_HALF_NS / REF_CLK_NS;
   // Access sequencer states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_EARLY = 4'h2,
      ST_ALIGN = 4'h4,
      ST_CYCLE = 4'h8
   } cmbp_state_t;
   // Pins driven by the memory side
   typedef struct packed {
      logic        addr_tristate_enable;
      logic        addr_latch_enable;
      logic        addr_pipe_select;
      logic        endian_select;
      logic [3:0]  byte_lane_capture;
      logic        bus_split_select;
      logic        data_drive_enable;
      logic        mem_abort;
      logic [31:0] bidir_data_in;
      logic [31:0] read_bus;
   } cmbp_pin_in_t;
   // Address and attribute pins
   typedef struct packed {
      logic [31:0] addr;
      logic        lock;
      logic [1:0]  access_size;
      logic        write_not_read;
      logic        instr_fetch_flag;
      logic        privilege_flag;
   } cmbp_addr_pins_t;
endpackage
